// File: srxsb_defines.vh
// Constants of the serial receive status and baud block: register
// offsets, field positions, reset values and divider figures.
// Assumes inclusion by its bare name from the core design file.
`ifndef SRXSB_DEFINES_VH
`define SRXSB_DEFINES_VH

// ****************************************************************
// Register offsets on the byte-wide register port
// ****************************************************************
`define SRXSB_OFS_STATUS_ONE    8'h16
`define SRXSB_OFS_STATUS_TWO    8'h17
`define SRXSB_OFS_DATA_BUFFER   8'h18
`define SRXSB_OFS_RATE_SELECT   8'h19
`define SRXSB_OFS_CONTROL_THREE 8'h1A

// ****************************************************************
// Field positions
// ****************************************************************
`define SRXSB_S1_RXFULL_BIT     5
`define SRXSB_S1_FRAMING_BIT    1
`define SRXSB_S1_PARITY_BIT     0
`define SRXSB_S2_BREAK_BIT      1
`define SRXSB_S2_ACTIVE_BIT     0
`define SRXSB_C3_NINTH_BIT      7
`define SRXSB_C3_FRAMING_IRQ_ENABLE_BIT       1
`define SRXSB_C3_PARITY_IRQ_ENABLE_BIT       0
`define SRXSB_RS_PRESCALE_HI    5
`define SRXSB_RS_PRESCALE_LO    4
`define SRXSB_RS_RATE_HI        2
`define SRXSB_RS_RATE_LO        0

// ****************************************************************
// Reset values
// ****************************************************************
`define SRXSB_RST_RATE_SELECT   8'h00
`define SRXSB_RST_IRQ_ENABLE    1'b0
`define SRXSB_RST_FLAG          1'b0

// ****************************************************************
// Divider figures: fixed front divide, prescaler codes, oversample
// ****************************************************************
`define SRXSB_FRONT_DIV         3'h4
`define SRXSB_PD_CODE0          4'h1
`define SRXSB_PD_CODE1          4'h3
`define SRXSB_PD_CODE2          4'h4
`define SRXSB_PD_CODE3          4'hD
`define SRXSB_OVERSAMPLE        5'h10

`endif

// File: srxsb_divider.v
// Programmable divider stage: counts enable pulses and emits one
// registered tick every div_i of them.
// Assumes div_i is at least one and stays stable between clears.
`timescale 1ns/1ps

module srxsb_divider #(
    parameter W = 8
) (
    // Clock and reset.
    input  wire         clk_i,
    input  wire         rst_n_i,
    // Control.
    input  wire         clr_i,
    input  wire         en_i,
    input  wire [W-1:0] div_i,
    // Output tick, one cycle long.
    output reg          tick_o
);

    localparam [W-1:0] ONE = 1;

    reg [W-1:0] count_q;

    // Restart on clear so a new setting never runs off a stale count.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= {W{1'b0}};
            tick_o  <= 1'b0;
        end else if (clr_i) begin
            count_q <= {W{1'b0}};
            tick_o  <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (en_i) begin
                if (count_q + ONE == div_i) begin
                    count_q <= {W{1'b0}};
                    tick_o  <= 1'b1;
                end else begin
                    count_q <= count_q + ONE;
                end
            end
        end
    end

endmodule // srxsb_divider

// File: srxsb_data_buffer.v
// Shared receive and transmit data buffer with the received ninth bit.
// Assumes load strobes are one cycle long; reset does not touch it.
`timescale 1ns/1ps

module srxsb_data_buffer (
    // Clock.
    input  wire       clk_i,
    // Receive side.
    input  wire       rx_load_i,
    input  wire [7:0] rx_byte_i,
    input  wire       rx_ninth_i,
    // Transmit side.
    input  wire       tx_load_i,
    input  wire [7:0] tx_byte_i,
    // Stored contents.
    output reg  [7:0] received_byte_o,
    output reg        received_ninth_o,
    output reg  [7:0] transmit_byte_o
);

    // No reset on purpose: the buffer keeps its contents through reset.
    always @(posedge clk_i) begin
        if (rx_load_i) begin
            received_byte_o  <= rx_byte_i;
            received_ninth_o <= rx_ninth_i;
        end
        if (tx_load_i) begin
            transmit_byte_o <= tx_byte_i;
        end
    end

endmodule // srxsb_data_buffer

// File: srxsb_core.v
// Receive status flags, data buffer access and baud divider chain of
// an asynchronous serial interface.
// Assumes a neighbouring receive engine that reports character events
// as one-cycle pulses, and a register master with one-cycle strobes.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "srxsb_defines.vh"

// Behaviour
// - Framing error flag sets when a stop bit samples low.
// - Error interrupt while framing flag and its enable are both set.
// - Framing flag clears on status one read then data buffer read.
// - Parity mismatch sets parity flag; with its enable, interrupts.
// - Parity flag clears on status one read then data buffer read.
// - Reset clears framing, parity and break flags.
// - Break sets break flag, framing error and receiver full.
// - Break in nine-bit mode clears the received ninth bit.
// - Break flag never requests an interrupt.
// - Break flag clears on status two read then data buffer read.
// - After clearing, break flag re-arms only once the line idles high.
// - Low sample in first sample slot sets reception active flag.
// - False start or idle character clears reception active flag.
// - Reception active flag is read-only and never interrupts.
// - Reset leaves data buffer contents unchanged.
// - One rate setting serves receiver and transmitter alike.
// - Prescaler field 00,01,10,11 divides by 1,3,4,13.
// - Rate field divides by two to the power of its value.
// - Reset clears prescaler and rate fields to divide by one.
// - Bit rate is clock over 64 times prescale times rate divisor.
// - Receiver full sets when a character lands in the buffer.
module srxsb_core (
    // Clock and reset.
    input  wire       clk_i,
    input  wire       rst_n_i,
    // Register port.
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    // Receive engine events.
    input  wire       rx_done_i,
    input  wire [7:0] rx_byte_i,
    input  wire       rx_ninth_i,
    input  wire       rx_stop_bit_i,
    input  wire       rx_parity_err_i,
    input  wire       rx_break_i,
    input  wire       rx_line_i,
    input  wire       rx_start_low_i,
    input  wire       rx_false_start_i,
    input  wire       rx_idle_char_i,
    input  wire       nine_bit_mode_i,
    // Rate ticks for the receive and transmit engines.
    output wire       rx_tick_o,
    output wire       tx_tick_o,
    // Transmit hand-off.
    output reg        tx_load_o,
    output wire [7:0] tx_byte_o,
    // Status towards the rest of the interface.
    output reg        receiver_full_o,
    output wire       received_ninth_o,
    output reg        error_irq_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg        framing_error_flag_q;
    reg        parity_error_flag_q;
    reg        break_detected_flag_q;
    reg        reception_active_flag_q;
    reg        framing_irq_enable_q;
    reg        parity_irq_enable_q;
    reg  [7:0] serial_rate_select_q;
    reg        fe_armed_q;
    reg        pe_armed_q;
    reg        rf_armed_q;
    reg        bk_armed_q;
    reg        break_block_q;
    reg  [7:0] rdata_d;
    reg  [3:0] prescale_divisor;
    reg  [7:0] rate_divisor;
    reg  [7:0] rx_load_byte;
    reg        rx_load_ninth;

    wire [7:0] received_byte;
    wire       sel_status_one;
    wire       sel_status_two;
    wire       sel_data;
    wire       sel_rate;
    wire       sel_control;
    wire       rd_status_one;
    wire       rd_status_two;
    wire       rd_data;
    wire       wr_rate;
    wire       wr_control;
    wire       wr_data;
    wire       break_take;
    wire       rx_load;
    wire       fe_set;
    wire       pe_set;
    wire       rf_set;
    wire       front_tick;
    wire       prescale_tick;
    wire [1:0] prescaler_field;
    wire [2:0] rate_select_field;

    // ****************************************************************
    // Address decode
    // ****************************************************************

    // Unmapped addresses are ignored on write and read back as zero.
    assign sel_status_one = (addr_i == `SRXSB_OFS_STATUS_ONE);
    assign sel_status_two = (addr_i == `SRXSB_OFS_STATUS_TWO);
    assign sel_data       = (addr_i == `SRXSB_OFS_DATA_BUFFER);
    assign sel_rate       = (addr_i == `SRXSB_OFS_RATE_SELECT);
    assign sel_control    = (addr_i == `SRXSB_OFS_CONTROL_THREE);
    assign rd_status_one  = rd_i & sel_status_one;
    assign rd_status_two  = rd_i & sel_status_two;
    assign rd_data        = rd_i & sel_data;
    assign wr_rate        = wr_i & sel_rate;
    assign wr_control     = wr_i & sel_control;
    assign wr_data        = wr_i & sel_data;

    // ****************************************************************
    // Receive events
    // ****************************************************************

    // A break is only reported once per idle-high gap on the line.
    assign break_take = rx_break_i & ~break_block_q;
    assign rx_load    = rx_done_i | rx_break_i;
    assign fe_set     = (rx_done_i & ~rx_stop_bit_i)
                      | rx_break_i;
    assign pe_set     = rx_done_i & rx_parity_err_i;
    assign rf_set     = rx_load;

    // A break character lands as all zeros with its ninth bit cleared.
    always @* begin
        rx_load_byte  = rx_byte_i;
        rx_load_ninth = nine_bit_mode_i ? rx_ninth_i : rx_byte_i[7];
        if (rx_break_i) begin
            rx_load_byte  = 8'h00;
            rx_load_ninth = 1'b0;
        end
    end

    // ****************************************************************
    // Status flags and their two-step clear sequences
    // ****************************************************************

    // A status read arms the clear only for flags seen set at that
    // read; the later data read then clears them. Any set arriving in
    // the clearing cycle wins so no event is lost.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            framing_error_flag_q  <= `SRXSB_RST_FLAG;
            parity_error_flag_q   <= `SRXSB_RST_FLAG;
            break_detected_flag_q <= `SRXSB_RST_FLAG;
            receiver_full_o       <= `SRXSB_RST_FLAG;
            fe_armed_q            <= 1'b0;
            pe_armed_q            <= 1'b0;
            rf_armed_q            <= 1'b0;
            bk_armed_q            <= 1'b0;
        end else begin
            if (rd_status_one) begin
                fe_armed_q <= framing_error_flag_q;
                pe_armed_q <= parity_error_flag_q;
                rf_armed_q <= receiver_full_o;
            end else if (rd_data) begin
                fe_armed_q <= 1'b0;
                pe_armed_q <= 1'b0;
                rf_armed_q <= 1'b0;
            end
            if (rd_status_two) begin
                bk_armed_q <= break_detected_flag_q;
            end else if (rd_data) begin
                bk_armed_q <= 1'b0;
            end
            if (fe_set) begin
                framing_error_flag_q <= 1'b1;
            end else if (rd_data & fe_armed_q) begin
                framing_error_flag_q <= 1'b0;
            end
            if (pe_set) begin
                parity_error_flag_q <= 1'b1;
            end else if (rd_data & pe_armed_q) begin
                parity_error_flag_q <= 1'b0;
            end
            if (rf_set) begin
                receiver_full_o <= 1'b1;
            end else if (rd_data & rf_armed_q) begin
                receiver_full_o <= 1'b0;
            end
            if (break_take) begin
                break_detected_flag_q <= 1'b1;
            end else if (rd_data & bk_armed_q) begin
                break_detected_flag_q <= 1'b0;
            end
        end
    end

    // Block further break reports until the line has returned high.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            break_block_q <= 1'b0;
        end else if (rx_break_i) begin
            break_block_q <= 1'b1;
        end else if (rx_line_i) begin
            break_block_q <= 1'b0;
        end
    end

    // Reception activity has no software write path and no interrupt.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reception_active_flag_q <= `SRXSB_RST_FLAG;
        end else if (rx_start_low_i) begin
            reception_active_flag_q <= 1'b1;
        end else if (rx_false_start_i | rx_idle_char_i) begin
            reception_active_flag_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupt enables and error request
    // ****************************************************************

    // Only framing and parity errors feed the request; break and
    // reception activity are left out deliberately.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            framing_irq_enable_q <= `SRXSB_RST_IRQ_ENABLE;
            parity_irq_enable_q  <= `SRXSB_RST_IRQ_ENABLE;
            error_irq_o          <= 1'b0;
        end else begin
            if (wr_control) begin
                framing_irq_enable_q <= wdata_i[`SRXSB_C3_FRAMING_IRQ_ENABLE_BIT];
                parity_irq_enable_q  <= wdata_i[`SRXSB_C3_PARITY_IRQ_ENABLE_BIT];
            end
            error_irq_o <= (framing_error_flag_q & framing_irq_enable_q)
                         | (parity_error_flag_q & parity_irq_enable_q);
        end
    end

    // ****************************************************************
    // Data buffer and transmit hand-off
    // ****************************************************************

    // One byte location: reads see received data, writes feed transmit.
    srxsb_data_buffer u_buffer (
        .clk_i            (clk_i),
        .rx_load_i        (rx_load),
        .rx_byte_i        (rx_load_byte),
        .rx_ninth_i       (rx_load_ninth),
        .tx_load_i        (wr_data),
        .tx_byte_i        (wdata_i),
        .received_byte_o  (received_byte),
        .received_ninth_o (received_ninth_o),
        .transmit_byte_o  (tx_byte_o)
    );

    // The load pulse lines up with the new byte at the buffer output.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_load_o <= 1'b0;
        end else begin
            tx_load_o <= wr_data;
        end
    end

    // ****************************************************************
    // Rate select register and divider chain
    // ****************************************************************

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_rate_select_q <= `SRXSB_RST_RATE_SELECT;
        end else if (wr_rate) begin
            serial_rate_select_q <= wdata_i;
        end
    end

    assign prescaler_field   =
        serial_rate_select_q[`SRXSB_RS_PRESCALE_HI:`SRXSB_RS_PRESCALE_LO];
    assign rate_select_field =
        serial_rate_select_q[`SRXSB_RS_RATE_HI:`SRXSB_RS_RATE_LO];

    // Decode both fields into plain divisors.
    always @* begin
        case (prescaler_field)
            2'b00:   prescale_divisor = `SRXSB_PD_CODE0;
            2'b01:   prescale_divisor = `SRXSB_PD_CODE1;
            2'b10:   prescale_divisor = `SRXSB_PD_CODE2;
            2'b11:   prescale_divisor = `SRXSB_PD_CODE3;
            default: prescale_divisor = `SRXSB_PD_CODE0;
        endcase
        rate_divisor = 8'h01 << rate_select_field;
    end

    // Clock over 4, PD, BD gives the 16x sampling tick, and a further
    // 16 gives the bit tick: clock over 64*PD*BD overall. A rate write
    // restarts the chain, trading one partial period for a clean start.
    srxsb_divider #(.W(3)) u_front (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (wr_rate),
        .en_i    (1'b1),
        .div_i   (`SRXSB_FRONT_DIV),
        .tick_o  (front_tick)
    );

    srxsb_divider #(.W(4)) u_prescale (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (wr_rate),
        .en_i    (front_tick),
        .div_i   (prescale_divisor),
        .tick_o  (prescale_tick)
    );

    srxsb_divider #(.W(8)) u_rate (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (wr_rate),
        .en_i    (prescale_tick),
        .div_i   (rate_divisor),
        .tick_o  (rx_tick_o)
    );

    // The transmitter shares the same chain, so both ends agree.
    srxsb_divider #(.W(5)) u_bit (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (wr_rate),
        .en_i    (rx_tick_o),
        .div_i   (`SRXSB_OVERSAMPLE),
        .tick_o  (tx_tick_o)
    );

    // ****************************************************************
    // Read data
    // ****************************************************************

    // Read data stand only in the cycle after the strobe.
    always @* begin
        rdata_d = 8'h00;
        if (rd_i) begin
            if (sel_status_one) begin
                rdata_d[`SRXSB_S1_RXFULL_BIT]  = receiver_full_o;
                rdata_d[`SRXSB_S1_FRAMING_BIT] = framing_error_flag_q;
                rdata_d[`SRXSB_S1_PARITY_BIT]  = parity_error_flag_q;
            end else if (sel_status_two) begin
                rdata_d[`SRXSB_S2_BREAK_BIT]  = break_detected_flag_q;
                rdata_d[`SRXSB_S2_ACTIVE_BIT] = reception_active_flag_q;
            end else if (sel_data) begin
                rdata_d = received_byte;
            end else if (sel_rate) begin
                rdata_d = serial_rate_select_q;
            end else if (sel_control) begin
                rdata_d[`SRXSB_C3_NINTH_BIT] = received_ninth_o;
                rdata_d[`SRXSB_C3_FRAMING_IRQ_ENABLE_BIT]  = framing_irq_enable_q;
                rdata_d[`SRXSB_C3_PARITY_IRQ_ENABLE_BIT]  = parity_irq_enable_q;
            end
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rdata_d;
        end
    end

endmodule // srxsb_core

// File: srxsb_remote.sv
// Far serial device as the receive engine reports it to the core.
// Assumes one request at a time from the bench; kind 0 means none.
`timescale 1ns/1ps

module srxsb_remote (
    // Clock and request.
    input  wire       clk_i,
    input  wire [2:0] kind_i,
    input  wire [7:0] byte_i,
    // Engine events.
    output reg        done_o,
    output reg        stop_o,
    output reg        perr_o,
    output reg        brk_o,
    output reg        line_o,
    output reg        low_o,
    output reg        fls_o,
    output reg        idle_o,
    output reg  [7:0] byte_o,
    output reg        ninth_o
);
    // Quiet at time zero: line idle high, no pulses.
    initial {done_o, perr_o, brk_o, low_o, fls_o, idle_o} = 6'h00;
    initial {stop_o, line_o, byte_o, ninth_o} = 11'h7FF;

    // Pulses last one cycle; stale data flip so nothing matches by luck.
    always @(posedge clk_i) begin
        done_o  <= kind_i != 3'h0 && kind_i < 3'h4;
        stop_o  <= kind_i != 3'h2;
        perr_o  <= kind_i == 3'h3;
        brk_o   <= kind_i == 3'h4;
        low_o   <= kind_i == 3'h5;
        fls_o   <= kind_i == 3'h6;
        idle_o  <= kind_i == 3'h7;
        byte_o  <= kind_i != 3'h0 && kind_i < 3'h4 ? byte_i : ~byte_o;
        ninth_o <= kind_i != 3'h0 && kind_i < 3'h4 ? byte_i[7] : ~ninth_o;
        // A break leaves the line low until later traffic lifts it.
        line_o  <= kind_i == 3'h4 ? 1'b0 :
                   (kind_i == 3'h0 ? line_o : 1'b1);
    end
endmodule // srxsb_remote

// File: srxsb_core_assertions.sv
// Port-level checks of the serial receive status and baud core.
// Assumes a bind into srxsb_core; only its ports are seen.
`timescale 1ns/1ps

module srxsb_core_assertions (
    // Clock, reset and register port.
    input wire       clk_i,
    input wire       rst_n_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire [7:0] rdata_o,
    // Receive events and status outputs.
    input wire       rx_done_i,
    input wire       rx_ninth_i,
    input wire       rx_break_i,
    input wire       nine_bit_mode_i,
    input wire       tx_load_o,
    input wire [7:0] tx_byte_o,
    input wire       receiver_full_o,
    input wire       received_ninth_o,
    input wire       error_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // Plain helpers, so that $past only ever sees a single signal.
    wire buf_rd_w = rd_i & (addr_i == 8'h18);
    wire event_w  = rx_done_i | rx_break_i;
    sequence s_buf_wr; wr_i && addr_i == 8'h18; endsequence
    sequence s_char; event_w; endsequence

    rd_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    tx_load_a: assert property
        (s_buf_wr |=> tx_load_o && tx_byte_o == $past(wdata_i))
        else $error("buffer write not handed to transmitter");
    tx_cause_a: assert property
        (tx_load_o |-> $past(wr_i) && $past(addr_i) == 8'h18)
        else $error("transmit load without buffer write");
    full_set_a: assert property (s_char |=> receiver_full_o)
        else $error("receiver full not set by character");
    full_clr_a: assert property
        ($fell(receiver_full_o) |-> $past(buf_rd_w))
        else $error("receiver full cleared without buffer read");
    brk_ninth_a: assert property
        (rx_break_i && nine_bit_mode_i |=> !received_ninth_o)
        else $error("ninth bit survived a break");
    ninth_load_a: assert property
        (rx_done_i && nine_bit_mode_i |=>
            received_ninth_o == $past(rx_ninth_i))
        else $error("ninth bit not loaded with character");
    irq_rise_a: assert property
        ($rose(error_irq_o) |-> $past(event_w, 2) || $past(wr_i, 2))
        else $error("error request raised without cause");
    irq_fall_a: assert property
        ($fell(error_irq_o) |-> $past(buf_rd_w, 2) || $past(wr_i, 2))
        else $error("error request dropped without clear");
endmodule // srxsb_core_assertions

bind srxsb_core srxsb_core_assertions i_chk (.*);

// File: srxsb_core_bench.sv
// Self-checking bench of the serial receive status and baud core.
// Assumes the remote model feeds the receive events; no other parts.
`timescale 1ns/1ps

module srxsb_core_bench;
    reg        clk_i = 1'b0;
    reg        rst_n_i = 1'b0;
    reg  [7:0] addr_i = 8'h00;
    reg  [7:0] wdata_i = 8'h00;
    reg        wr_i = 1'b0;
    reg        rd_i = 1'b0;
    reg        nine_bit_mode_i = 1'b0;
    reg  [2:0] kind = 3'h0;
    reg  [7:0] pbyte = 8'h00;
    wire [7:0] rdata_o, rx_byte_i, tx_byte_o;
    wire       rx_done_i, rx_ninth_i, rx_stop_bit_i, rx_parity_err_i;
    wire       rx_break_i, rx_line_i, rx_start_low_i, rx_false_start_i;
    wire       rx_idle_char_i, rx_tick_o, tx_tick_o, tx_load_o;
    wire       receiver_full_o, received_ninth_o, error_irq_o;
    integer    fails = 0;
    integer    cmp_count = 0;

    srxsb_core i_dut (.*);
    srxsb_remote i_far (.clk_i(clk_i), .kind_i(kind), .byte_i(pbyte),
        .done_o(rx_done_i), .stop_o(rx_stop_bit_i),
        .perr_o(rx_parity_err_i), .brk_o(rx_break_i), .line_o(rx_line_i),
        .low_o(rx_start_low_i), .fls_o(rx_false_start_i),
        .idle_o(rx_idle_char_i), .byte_o(rx_byte_i), .ninth_o(rx_ninth_i));

    // 25 MHz bus clock.
    always #20 clk_i = ~clk_i;

    task chk(input string nm, input [15:0] e, input [15:0] g);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One write, or one read judged under a mask in its answer cycle.
    task bus(input w, input [7:0] a, input [7:0] d, input [7:0] m);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
        if (!w) chk($sformatf("reg %h", a), d, rdata_o & m);
    endtask

    // Ask the remote for one event and let the flags settle.
    task ev(input [2:0] k, input [7:0] b);
        @(posedge clk_i);
        kind <= k;
        pbyte <= b;
        @(posedge clk_i);
        kind <= 3'h0;
        repeat (2) @(posedge clk_i);
    endtask

    task t_frame;
        bus(1, 8'h1A, 8'h02, 8'h00);
        ev(3'h2, 8'hA5);
        bus(0, 8'h16, 8'h22, 8'h23);
        chk("irq", 1, error_irq_o);
        bus(0, 8'h18, 8'hA5, 8'hFF);
        bus(0, 8'h16, 8'h00, 8'h23);
        chk("irq", 0, error_irq_o);
    endtask

    task t_parity;
        bus(1, 8'h1A, 8'h00, 8'h00);
        ev(3'h3, 8'h5A);
        bus(0, 8'h16, 8'h21, 8'h23);
        chk("irq", 0, error_irq_o);
        bus(1, 8'h1A, 8'h01, 8'h00);
        bus(0, 8'h16, 8'h21, 8'h23);
        chk("irq", 1, error_irq_o);
        bus(0, 8'h18, 8'h5A, 8'hFF);
        bus(0, 8'h16, 8'h00, 8'h23);
        chk("irq", 0, error_irq_o);
    endtask

    task t_active;
        ev(3'h5, 8'h00);
        bus(0, 8'h17, 8'h01, 8'h01);
        bus(1, 8'h17, 8'h00, 8'h00);
        bus(0, 8'h17, 8'h01, 8'h01);
        ev(3'h6, 8'h00);
        bus(0, 8'h17, 8'h00, 8'h01);
        ev(3'h5, 8'h00);
        ev(3'h7, 8'h00);
        bus(0, 8'h17, 8'h00, 8'h01);
    endtask

    task t_break;
        @(posedge clk_i) nine_bit_mode_i <= 1'b1;
        ev(3'h1, 8'h80);
        bus(0, 8'h1A, 8'h80, 8'h80);
        ev(3'h4, 8'h00);
        bus(0, 8'h1A, 8'h00, 8'h80);
        bus(0, 8'h16, 8'h22, 8'h23);
        bus(0, 8'h17, 8'h02, 8'h02);
        chk("irq", 0, error_irq_o);
        bus(0, 8'h18, 8'h00, 8'hFF);
        bus(0, 8'h17, 8'h00, 8'h02);
        ev(3'h4, 8'h00);
        bus(0, 8'h17, 8'h00, 8'h02);
        ev(3'h7, 8'h00);
        ev(3'h4, 8'h00);
        bus(0, 8'h17, 8'h02, 8'h02);
    endtask

    // Flags stay set into a mid-run reset; the buffer must survive it.
    task t_reset;
        ev(3'h3, 8'h3C);
        bus(1, 8'h19, 8'h35, 8'h00);
        bus(1, 8'h1A, 8'h03, 8'h00);
        bus(1, 8'h18, 8'hC3, 8'h00);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        bus(0, 8'h16, 8'h00, 8'h23);
        bus(0, 8'h17, 8'h00, 8'h02);
        bus(0, 8'h19, 8'h00, 8'hFF);
        bus(0, 8'h1A, 8'h00, 8'h03);
        bus(0, 8'h18, 8'h3C, 8'hFF);
        chk("tx_byte", 8'hC3, tx_byte_o);
        bus(1, 8'h20, 8'hFF, 8'h00);
        bus(0, 8'h20, 8'h00, 8'hFF);
        bus(0, 8'h19, 8'h00, 8'hFF);
    endtask

    // One full bit period, and the sampling ticks inside it.
    task t_rate(input [1:0] p, input [2:0] r);
        integer n, k, pd;
        pd = p == 2'h0 ? 1 : p == 2'h1 ? 3 : p == 2'h2 ? 4 : 13;
        bus(1, 8'h19, {2'h0, p, 1'b0, r}, 8'h00);
        bus(0, 8'h19, {2'h0, p, 1'b0, r}, 8'hFF);
        n = 0;
        while (tx_tick_o !== 1'b1 && n < 20000) begin
            @(posedge clk_i);
            #1 n = n + 1;
        end
        n = 0;
        k = 0;
        do begin
            @(posedge clk_i);
            #1 n = n + 1;
            k = k + (rx_tick_o === 1'b1);
        end while (tx_tick_o !== 1'b1 && n < 20000);
        chk("bit period", (64 * pd) << r, n);
        chk("rx ticks", 16, k);
    endtask

    task finish_test;
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence after a 16-cycle reset.
    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_frame;
        t_parity;
        t_active;
        t_break;
        t_reset;
        t_rate(2'h0, 3'h0);
        t_rate(2'h1, 3'h1);
        t_rate(2'h2, 3'h2);
        t_rate(2'h3, 3'h3);
        t_rate(2'h0, 3'h7);
        finish_test;
    end

    // Watchdog well beyond the roughly 33k cycles the tests need.
    initial begin
        #(60000 * 40);
        fails = fails + 1;
        finish_test;
    end
endmodule // srxsb_core_bench
